// ### hw/orf_access.sv
// on-chip ram and flash access controller with ahb-lite register port
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - ram is 8192 or 4096 bytes, 8-bit
// - ram accesses wait only while a flash access or byte-port stall is pending
// - large ram window E000h-FFFFh in upper page
// - small ram window starts at F000h
// - reset: ram enabled, upper base FFh
// - ram wins over flash and chip selects
// - external masters never reach ram once grant has passed the two-stage synchroniser
// - ram control bit 7 enable, rest zero
// - flash 128/64 pages of eight 128-byte rows; byte port reaches all 128 pages in both variants
// - 256-byte info area only via port
// - protected 16 KB blocks refuse programming
// - flash reads get automatic wait states
// - mapped reads main array, need enable
// - byte port reads flash, auto-increments address
// - byte or up-to-row burst programming accepted
// - writes become flash program protocol
// - byte-port write stalls cpu until done
// - single-byte program takes 66 to 85 us
module orf_access
  import orf_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite register port
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu memory bus
  input wire logic mreq,
  input wire logic mwrite,
  input wire logic [23:0] maddr,
  input wire logic [7:0] mwdata,
  output logic [7:0] mrdata,
  output logic mready,
  // chip select qualification and bus grant pin
  input wire logic cs_req,
  input wire logic busack_n,
  output logic cs_out
);

  typedef struct packed {
    logic ram_en;
    logic [7:0] ram_upper;
    logic [7:0] page;
    logic [2:0] row;
    logic [6:0] col;
    logic [7:0] data;
    logic [7:0] acc;
    logic [7:0] prot;
    logic prot_err;
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic fl_pend;
    logic fl_from_port;
    logic fl_write;
    logic [7:0] mrdata;
    logic mready;
    logic cs_out;
    logic ack_s1;
    logic ack_s2;
  } orf_top_s;

  orf_top_s r_reg, r_next;
  orf_mem_if mem ();
  logic ram_hit;
  logic fl_hit;
  logic ram_we;
  logic [12:0] ram_addr;
  logic [7:0] ram_rdata;
  logic [15:0] ram_base;
  logic [16:0] port_addr;
  logic [2:0] blk;
  logic granted;

  orf_ram i_orf_ram (
    .hclk(hclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(mwdata),
    .rdata(ram_rdata)
  );

  orf_flash_seq i_orf_flash_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .mem(mem)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign ram_base = SMALL_VARIANT ? RAM_BASE_SMALL : RAM_BASE_BIG;
  assign granted = !r_reg.ack_s2;
  // grant blocks ram so an external master falls through to its chip select
  assign ram_hit = r_reg.ram_en && !granted && (maddr[23:16] == r_reg.ram_upper)
                   && (maddr[15:0] >= ram_base) && (maddr[15:0] <= RAM_TOP);
  assign fl_hit = !ram_hit && r_reg.acc[FL_ACC_EN_BIT]
                  && (maddr[23:17] == 7'h00)
                  && (!SMALL_VARIANT || !maddr[16]);
  assign ram_we = mreq && mwrite && ram_hit && !r_reg.fl_pend;
  assign ram_addr = SMALL_VARIANT ? {1'b0, maddr[11:0]} : maddr[12:0];
  assign port_addr = {r_reg.page[6:0], r_reg.row, r_reg.col};
  assign blk = r_reg.fl_from_port ? port_addr[16:14] : maddr[16:14];

  // ----------------------------------------------------------------
  // flash request carrier
  // ----------------------------------------------------------------
  assign mem.addr = r_reg.fl_from_port ? port_addr : maddr[16:0];
  assign mem.info_sel = r_reg.fl_from_port && r_reg.page[INFO_EN_BIT];
  assign mem.wdata = r_reg.fl_from_port ? r_reg.data : mwdata;
  assign mem.wait_cnt = (r_reg.acc[2:0] < RD_WAIT_MIN) ? RD_WAIT_MIN : r_reg.acc[2:0];
  assign mem.rd_req = r_reg.fl_pend && !r_reg.fl_write && !mem.busy && !mem.done;
  assign mem.wr_req = r_reg.fl_pend && r_reg.fl_write && !mem.busy && !mem.done
                      && !r_reg.prot[blk];

  always_comb begin
    logic [7:0] rd8;
    logic [7:0] wb;
    logic [16:0] inc;
    rd8 = 8'h00;
    wb = hwdata[7:0];
    inc = 17'h00000;
    r_next = r_reg;
    r_next.ack_s1 = busack_n;
    r_next.ack_s2 = r_reg.ack_s1;
    r_next.mready = 1'b0;
    r_next.cs_out = mreq && cs_req && !ram_hit;

    // ----------------------------------------------------------------
    // cpu memory side
    // ----------------------------------------------------------------
    if (mreq && !r_reg.mready && !r_reg.fl_pend && r_reg.hreadyout) begin
      if (ram_hit) begin
        r_next.mready = 1'b1;
        r_next.mrdata = ram_rdata;
      end else if (fl_hit) begin
        r_next.fl_pend = 1'b1;
        r_next.fl_from_port = 1'b0;
        r_next.fl_write = mwrite;
      end else begin
        r_next.mready = 1'b1;
        r_next.mrdata = 8'hFF;
      end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    // data phase: writes land here, read data was registered a cycle earlier
    if (r_reg.ap_valid) begin
      unique case (r_reg.ap_addr[11:2])
        RAM_CTRL_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.ram_en = wb[RAM_EN_BIT];
          end
        end
        RAM_UPPER_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.ram_upper = wb;
          end
        end
        FL_PAGE_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.page = wb;
          end
        end
        FL_ROW_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.row = wb[2:0];
          end
        end
        FL_COL_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.col = wb[6:0];
          end
        end
        FL_ACC_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.acc = wb;
          end
        end
        FL_PROT_IDX[9:0]: begin
          if (r_reg.ap_write) begin
            r_next.prot = wb;
          end
        end
        FL_STAT_IDX[9:0]: begin
          // a protect error in the same cycle wins over this clear
          if (r_reg.ap_write && wb[0]) begin
            r_next.prot_err = 1'b0;
          end
        end
        FL_DATA_IDX[9:0]: begin
          // hreadyout is already low: the data phase waits for the array
          r_next.fl_pend = 1'b1;
          r_next.fl_from_port = 1'b1;
          r_next.fl_write = r_reg.ap_write;
          if (r_reg.ap_write) begin
            r_next.data = wb;
          end
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
      r_next.ap_valid = 1'b0;
    end

    // ----------------------------------------------------------------
    // flash completion
    // ----------------------------------------------------------------
    if (r_reg.fl_pend && r_reg.fl_write && !mem.busy && !mem.done && r_reg.prot[blk]) begin
      r_next.prot_err = 1'b1;
      r_next.fl_pend = 1'b0;
      r_next.hreadyout = 1'b1;
      r_next.mready = !r_reg.fl_from_port;
    end else if (mem.done && r_reg.fl_pend) begin
      r_next.fl_pend = 1'b0;
      if (r_reg.fl_from_port) begin
        inc = port_addr + 17'h00001;
        r_next.col = inc[6:0];
        r_next.row = inc[9:7];
        r_next.page = {r_reg.page[7], inc[16:10]};
        r_next.hreadyout = 1'b1;
        if (!r_reg.fl_write) begin
          r_next.hrdata = {24'h000000, mem.rdata};
        end
      end else begin
        r_next.mready = 1'b1;
        r_next.mrdata = mem.rdata;
      end
    end

    // ----------------------------------------------------------------
    // address phase capture
    // ----------------------------------------------------------------
    // outputs are registered, so read data and the stall are set here
    // to stand already in the data phase that follows
    if (hready && r_next.hreadyout) begin
      r_next.ap_valid = hsel && htrans[1];
      r_next.ap_write = hwrite;
      r_next.ap_addr = haddr;
      if (hsel && htrans[1]) begin
        unique case (haddr[11:2])
          RAM_CTRL_IDX[9:0]: begin
            rd8 = {r_next.ram_en, 7'h00};
          end
          RAM_UPPER_IDX[9:0]: begin
            rd8 = r_next.ram_upper;
          end
          FL_PAGE_IDX[9:0]: begin
            rd8 = r_next.page;
          end
          FL_ROW_IDX[9:0]: begin
            rd8 = {5'h00, r_next.row};
          end
          FL_COL_IDX[9:0]: begin
            rd8 = {1'b0, r_next.col};
          end
          FL_ACC_IDX[9:0]: begin
            rd8 = r_next.acc;
          end
          FL_PROT_IDX[9:0]: begin
            rd8 = r_next.prot;
          end
          FL_STAT_IDX[9:0]: begin
            rd8 = {7'h00, r_next.prot_err};
          end
          FL_DATA_IDX[9:0]: begin
            // the array answer replaces this once the stall ends
            rd8 = r_next.hrdata[7:0];
            r_next.hreadyout = 1'b0;
          end
          default: begin
            rd8 = 8'h00;
          end
        endcase
        if (!hwrite) begin
          r_next.hrdata = {24'h000000, rd8};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.ram_en <= RAM_CTRL_RST[RAM_EN_BIT];
      r_reg.ram_upper <= RAM_UPPER_RST;
      r_reg.acc <= FL_ACC_RST;
      r_reg.prot <= FL_PROT_RST;
      r_reg.hreadyout <= 1'b1;
      // grant pin idles high, so the synchroniser starts released
      r_reg.ack_s1 <= 1'b1;
      r_reg.ack_s2 <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.hrdata;
  assign hreadyout = r_reg.hreadyout;
  assign hresp = 1'b0;
  assign mrdata = r_reg.mrdata;
  assign mready = r_reg.mready;
  assign cs_out = r_reg.cs_out;

endmodule : orf_access
`default_nettype wire

// ### hw/orf_flash_seq.sv
// flash array model with read wait states and self-timed byte program
`timescale 1ns/1ps
`default_nettype none
module orf_flash_seq
  import orf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request side
  orf_mem_if.seq mem
);

  typedef struct packed {
    orf_fl_state_e st;
    logic [12:0] cnt;
    logic done;
    logic [7:0] rdata;
  } orf_seq_s;

  orf_seq_s s_reg, s_next;
  // array kept whole; erase lies outside this block so contents start blank
  logic [7:0] main_mem [0:FL_PAGES_BIG*FL_ROWS*FL_ROW_BYTES-1];
  logic [7:0] info_mem [0:FL_INFO_BYTES-1];
  logic wr_main;
  logic wr_info;

  // blank cells read as ones until programmed
  initial begin
    for (int i = 0; i < FL_PAGES_BIG*FL_ROWS*FL_ROW_BYTES; i++) begin
      main_mem[i] = 8'hFF;
    end
    for (int i = 0; i < FL_INFO_BYTES; i++) begin
      info_mem[i] = 8'hFF;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    wr_main = 1'b0;
    wr_info = 1'b0;
    unique case (s_reg.st)
      FL_IDLE: begin
        if (mem.rd_req) begin
          s_next.st = FL_READ;
          s_next.cnt = {10'h000, mem.wait_cnt};
        end else if (mem.wr_req) begin
          s_next.st = FL_PROG;
          s_next.cnt = 13'(PGM_CYC);
        end
      end
      FL_READ: begin
        if (s_reg.cnt <= 13'h0001) begin
          s_next.st = FL_IDLE;
          s_next.done = 1'b1;
          s_next.rdata = mem.info_sel ? info_mem[mem.addr[7:0]] : main_mem[mem.addr];
        end else begin
          s_next.cnt = s_reg.cnt - 13'h0001;
        end
      end
      FL_PROG: begin
        if (s_reg.cnt <= 13'h0001) begin
          s_next.st = FL_IDLE;
          s_next.done = 1'b1;
          wr_main = ~mem.info_sel;
          wr_info = mem.info_sel;
        end else begin
          s_next.cnt = s_reg.cnt - 13'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{FL_IDLE, 13'h0000, 1'b0, 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  // programming only clears bits, like a real cell
  always_ff @(posedge hclk) begin
    if (wr_main) begin
      main_mem[mem.addr] <= main_mem[mem.addr] & mem.wdata;
    end
    if (wr_info) begin
      info_mem[mem.addr[7:0]] <= info_mem[mem.addr[7:0]] & mem.wdata;
    end
  end

  assign mem.busy = (s_reg.st != FL_IDLE);
  assign mem.done = s_reg.done;
  assign mem.rdata = s_reg.rdata;

endmodule : orf_flash_seq
`default_nettype wire

// ### hw/orf_mem_if.sv
// carrier between the access top and the flash sequencer
`timescale 1ns/1ps
`default_nettype none
interface orf_mem_if;
  logic rd_req;
  logic wr_req;
  logic [16:0] addr;
  logic info_sel;
  logic [7:0] wdata;
  logic [2:0] wait_cnt;
  logic busy;
  logic done;
  logic [7:0] rdata;
  modport ctrl (output rd_req, output wr_req, output addr, output info_sel, output wdata,
                output wait_cnt, input busy, input done, input rdata);
  modport seq (input rd_req, input wr_req, input addr, input info_sel, input wdata,
               input wait_cnt, output busy, output done, output rdata);
endinterface : orf_mem_if
`default_nettype wire

// ### hw/orf_pkg.sv
// shared constants and types for the on-chip ram and flash access block
package orf_pkg;

  // ----------------------------------------------------------------
  // register indices; the ahb byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] RAM_CTRL_IDX = 12'h0B4;
  localparam logic [11:0] RAM_UPPER_IDX = 12'h0B5;
  localparam logic [11:0] FL_PAGE_IDX = 12'h0FC;
  localparam logic [11:0] FL_ROW_IDX = 12'h0FD;
  localparam logic [11:0] FL_COL_IDX = 12'h0FE;
  localparam logic [11:0] FL_DATA_IDX = 12'h0F6;
  localparam logic [11:0] FL_ACC_IDX = 12'h0F8;
  localparam logic [11:0] FL_PROT_IDX = 12'h0FA;
  localparam logic [11:0] FL_STAT_IDX = 12'h0FB;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RAM_CTRL_RST = 8'h80;
  localparam logic [7:0] RAM_UPPER_RST = 8'hFF;
  localparam int RAM_EN_BIT = 7;
  localparam logic [7:0] FL_ACC_RST = 8'h00;
  localparam int FL_ACC_EN_BIT = 3;
  localparam logic [7:0] FL_PROT_RST = 8'h00;
  localparam int INFO_EN_BIT = 7;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int RAM_BYTES_BIG = 8192;
  localparam int RAM_BYTES_SMALL = 4096;
  localparam logic [15:0] RAM_BASE_BIG = 16'hE000;
  localparam logic [15:0] RAM_BASE_SMALL = 16'hF000;
  localparam logic [15:0] RAM_TOP = 16'hFFFF;
  localparam int FL_PAGES_BIG = 128;
  localparam int FL_PAGES_SMALL = 64;
  localparam int FL_ROWS = 8;
  localparam int FL_ROW_BYTES = 128;
  localparam int FL_INFO_BYTES = 256;
  localparam int FL_BLOCK_KB = 16;
  localparam int FL_BLOCKS_BIG = 8;

  // ----------------------------------------------------------------
  // timing at 10 mhz
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int PGM_MIN_US = 66;
  localparam int PGM_MAX_US = 85;
  localparam int PGM_CYC = (PGM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] RD_WAIT_MIN = 3'h1;

  typedef enum logic [1:0] {FL_IDLE, FL_READ, FL_PROG} orf_fl_state_e;

endpackage : orf_pkg

// ### hw/orf_ram.sv
// single-port on-chip data ram, zero wait states
`timescale 1ns/1ps
`default_nettype none
module orf_ram
  import orf_pkg::*;
(
  // clock
  input wire logic hclk,
  // access
  input wire logic we,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:RAM_BYTES_BIG-1];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // asynchronous read: the hit is answered in the cycle it is taken
  always_comb begin
    rdata = mem[addr];
  end

endmodule : orf_ram
`default_nettype wire

// ### testbench/onchip_ram_flash_access_test.sv
// self-checking bench for the ram and flash access block
`timescale 1ns/1ps
`default_nettype none
module onchip_ram_flash_access_test
  import orf_pkg::*;
();
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic cs_req = 1'b0;
  logic busack_n = 1'b1;
  logic cs_hi = 1'b0;
  logic hready, hreadyout, hresp, mreq, mwrite, mready, cs_out;
  logic [31:0] hrdata;
  logic [23:0] maddr;
  logic [7:0] mwdata, mrdata, b;
  logic [31:0] r;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  orf_access #(.SMALL_VARIANT(1'b0)) i_orf_access (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mreq(mreq), .mwrite(mwrite), .maddr(maddr), .mwdata(mwdata), .mrdata(mrdata),
    .mready(mready), .cs_req(cs_req), .busack_n(busack_n), .cs_out(cs_out));
  orf_cpu_model i_orf_cpu_model (.hclk(hclk), .hresetn(hresetn), .mreq(mreq),
    .mwrite(mwrite), .maddr(maddr), .mwdata(mwdata), .mrdata(mrdata), .mready(mready));
  // ------
  // bus tasks
  // ------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= i << 2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      @(posedge hclk);
    end
    r = hrdata;
    hwdata <= ~d;
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    ahb(1'b1, i, {24'h000000, d});
  endtask
  task automatic rd(input string s, input logic [11:0] i, input logic [7:0] e);
    ahb(1'b0, i, 32'h00000000);
    chk(s, {24'h000000, e}, r & 32'h000000FF);
  endtask
  task automatic cpu(input logic w, input logic [23:0] a, input logic [7:0] d);
    i_orf_cpu_model.access(w, a, d, b, n);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a hang ends the run; cs_hi remembers any chip select seen
  always @(posedge hclk) begin
    cyc++;
    if (cs_out === 1'b1) cs_hi <= 1'b1;
    if (cyc == 10000) begin
      num_errors++;
      final_report();
    end
  end
  // ------
  // tests
  // ------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    cs_req <= 1'b1;
    @(posedge hclk);
    rd("ram ctrl", RAM_CTRL_IDX, 8'h80);
    rd("ram upper", RAM_UPPER_IDX, 8'hFF);
    wr(RAM_CTRL_IDX, 8'h7F);
    rd("ctrl off", RAM_CTRL_IDX, 8'h00);
    wr(RAM_CTRL_IDX, 8'hFF);
    rd("ctrl on", RAM_CTRL_IDX, 8'h80);
    wr(12'h3FF, 8'h12);
    rd("unmapped", 12'h3FF, 8'h00);
    cpu(1'b0, 24'hFFE000, 8'h00);
    chk("ram wait", 2, n);
    wr(RAM_UPPER_IDX, 8'h7A);
    rd("ram upper", RAM_UPPER_IDX, 8'h7A);
    $display("test regs done");
    cs_hi = 1'b0;
    cpu(1'b1, 24'h7AE000, 8'hA5);
    cpu(1'b1, 24'h7AFFFF, 8'h3C);
    cpu(1'b0, 24'h7AE000, 8'h00);
    chk("ram lo", 8'hA5, b);
    chk("ram wait", 2, n);
    cpu(1'b0, 24'h7AFFFF, 8'h00);
    chk("ram hi", 8'h3C, b);
    chk("cs masked", 0, cs_hi);
    cpu(1'b0, 24'h7ADFFF, 8'h00);
    // let the chip-select monitor settle before looking at it
    @(posedge hclk);
    chk("below ram", 8'hFF, b);
    chk("cs below", 1, cs_hi);
    busack_n <= 1'b0;
    repeat (4) @(posedge hclk);
    cpu(1'b0, 24'h7AE000, 8'h00);
    chk("granted", 8'hFF, b);
    busack_n <= 1'b1;
    wr(RAM_CTRL_IDX, 8'h00);
    cpu(1'b0, 24'h7AE000, 8'h00);
    chk("ram off", 8'hFF, b);
    wr(RAM_CTRL_IDX, 8'h80);
    cpu(1'b0, 24'h7AE000, 8'h00);
    chk("ram back", 8'hA5, b);
    $display("test ram done");
    wr(FL_ACC_IDX, 8'h0B);
    wr(FL_PAGE_IDX, 8'h80);
    wr(FL_ROW_IDX, 8'h00);
    wr(FL_COL_IDX, 8'h00);
    // one program per byte and few per row keep the row well inside its time budget
    wr(FL_DATA_IDX, 8'hC3);
    chk("prog stall", 1, n >= 660 && n <= 850);
    rd("col inc", FL_COL_IDX, 8'h01);
    wr(FL_COL_IDX, 8'h00);
    rd("info byte", FL_DATA_IDX, 8'hC3);
    chk("port wait", 1, n > 0);
    rd("col inc", FL_COL_IDX, 8'h01);
    wr(FL_PAGE_IDX, 8'h00);
    cpu(1'b0, 24'h000000, 8'h00);
    chk("main byte", 8'hFF, b);
    chk("mem wait", 1, n > 2);
    cpu(1'b1, 24'h000001, 8'h5A);
    chk("mem prog", 1, n >= 660 && n <= 850);
    cpu(1'b0, 24'h000001, 8'h00);
    chk("mem byte", 8'h5A, b);
    wr(FL_PROT_IDX, 8'h01);
    wr(FL_COL_IDX, 8'h02);
    wr(FL_DATA_IDX, 8'h00);
    chk("prot fast", 1, n < 12);
    rd("prot flag", FL_STAT_IDX, 8'h01);
    wr(FL_COL_IDX, 8'h02);
    rd("prot byte", FL_DATA_IDX, 8'hFF);
    $display("test flash done");
    final_report();
  end
endmodule // onchip_ram_flash_access_test
`default_nettype wire

// ### testbench/orf_access_chk.sv
// checker for the ram and flash access block ports
`timescale 1ns/1ps
`default_nettype none
module orf_access_chk
  import orf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register port
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // cpu bus and selects
  input wire logic mreq,
  input wire logic mready,
  input wire logic cs_req,
  input wire logic busack_n,
  input wire logic cs_out
);
  // ------
  // helpers
  // ------
  localparam logic [11:0] DATA_A = FL_DATA_IDX << 2;
  localparam logic [11:0] CTL_A = RAM_CTRL_IDX << 2;
  logic [11:0] low_cnt_reg;
  logic ap;
  assign ap = hsel && htrans[1] && hready;
  // stall length, judged when hreadyout returns
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_reg <= 12'h000;
    end else begin
      low_cnt_reg <= hreadyout ? 12'h000 : low_cnt_reg + 12'h001;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------
  // assertions
  // ------
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  reg_nowait_a: assert property (ap && haddr != DATA_A |=> hreadyout)
    else $error("register access stalled");
  port_stall_a: assert property (ap && haddr == DATA_A |=> !hreadyout)
    else $error("data port not stalled");
  ctrl_rsvd_a: assert property (ap && !hwrite && haddr == CTL_A |=> hrdata[6:0] == 7'h00)
    else $error("ram ctrl low bits set");
  cs_gate_a: assert property (!(mreq && cs_req) |=> !cs_out)
    else $error("cs_out without request");
  grant_cs_a: assert property (!busack_n [*3] ##1 (!busack_n && mreq && cs_req) |=> cs_out)
    else $error("ram decoded while granted");
  mready_pulse_a: assert property (mready |=> !mready)
    else $error("mready longer than a cycle");
  mready_req_a: assert property (mready |-> $past(mreq))
    else $error("mready without mreq");
  prog_time_a: assert property ($rose(hreadyout) |->
    (low_cnt_reg <= 12 || (low_cnt_reg >= 660 && low_cnt_reg <= 850)))
    else $error("stall length out of range");
  cover property ($rose(hreadyout) && low_cnt_reg >= 660);
  cover property (cs_out);
  cover property (mready);
endmodule // orf_access_chk
bind orf_access orf_access_chk i_orf_access_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mreq(mreq), .mready(mready), .cs_req(cs_req),
  .busack_n(busack_n), .cs_out(cs_out));
`default_nettype wire

// ### testbench/orf_cpu_model.sv
// processor core model on the cpu memory bus
`timescale 1ns/1ps
`default_nettype none
module orf_cpu_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // memory bus
  output logic mreq,
  output logic mwrite,
  output logic [23:0] maddr,
  output logic [7:0] mwdata,
  input wire logic [7:0] mrdata,
  input wire logic mready
);
  initial begin
    mreq = 1'b0;
    mwrite = 1'b0;
    maddr = 24'h000000;
    mwdata = 8'h00;
  end
  // held until mready or 2000 cycles; one idle cycle between calls, no polling
  task automatic access(input logic w, input logic [23:0] a, input logic [7:0] d,
    output logic [7:0] r, output int n);
    n = 0;
    @(posedge hclk);
    mreq <= 1'b1;
    mwrite <= w;
    maddr <= a;
    mwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (mready !== 1'b1 && n < 2000);
    r = mrdata;
    mreq <= 1'b0;
    // released address and data lines must not keep the last value
    maddr <= ~a;
    mwdata <= ~d;
  endtask
endmodule // orf_cpu_model
`default_nettype wire
